// >>> cssc_pkg.sv
// package: register offsets, field positions, reset values and timing counts
// assumes: apb slave with 32-bit data, registers in the low 16 bits
package cssc_pkg;
  // offsets 0x2 and 0x4 are register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_OSC_CTRL = 8'h04;
  localparam logic [7:0] IDX_MAIN_CTRL = 8'h00;
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_OSC_CTRL = {IDX_OSC_CTRL, 2'b00};
  localparam logic [9:0] ADDR_MAIN_CTRL = {IDX_MAIN_CTRL, 2'b00};
  // status fields
  localparam int ST_FINE_UNLOCK = 15;
  localparam int ST_COARSE_UNLOCK = 14;
  localparam int ST_REF_LOSS = 13;
  localparam int ST_FINE_LOCKED = 6;
  localparam int ST_COARSE_LOCKED = 5;
  localparam int ST_PLL_OFF = 4;
  localparam int ST_CRYSTAL_PIN_READY = 2;
  // oscillator control fields
  localparam int OC_RELAX_PD = 15;
  localparam int OC_RELAX_SB_N = 14;
  localparam int OC_CRYSTAL_PIN_LOW_PWR = 13;
  localparam int OC_DIRECT_CLK = 12;
  localparam int OC_RANGE = 11;
  localparam int OC_EXT_INPUT_SELECT = 10;
  localparam logic [15:0] OSC_CTRL_RESET = 16'h4200;
  // main control fields (own layout)
  localparam int MC_PLL_OFF = 0;
  localparam int MC_COARSE_IE = 1;
  localparam int MC_FINE_IE = 2;
  localparam int MC_REF_LOSS_IE = 3;
  localparam int MC_PRESCALER_EXT = 4;
  localparam logic [15:0] MAIN_CTRL_RESET = 16'h0000;
  localparam logic [15:0] MAIN_CTRL_MASK = 16'h001f;
  // timing
  localparam int PLL_OFF_DELAY = 4;
endpackage : cssc_pkg

// >>> cssc_delay.sv
// delay line: holds a one-bit level for a fixed number of clock cycles
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module cssc_delay #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic din,
  output logic dout
);
  logic [DEPTH-1:0] stage;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= '0;
    end else begin
      stage <= {stage[DEPTH-2:0], din};
    end
  end
  assign dout = stage[DEPTH-1];
endmodule : cssc_delay
`default_nettype wire

// >>> cssc_flag.sv
// sticky write-one-to-clear flag: hardware set beats software clear
// assumes: set and clear are single-cycle qualified strobes
`timescale 1ns/100ps
`default_nettype none
module cssc_flag (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule : cssc_flag
`default_nettype wire

// >>> cssc_top.sv
// clock synthesis status and oscillator control, apb slave
// assumes: lock, reference and oscillator inputs are synchronous to pclk
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module cssc_top
  import cssc_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pll and oscillator status inputs
  input wire logic fine_locked_in,
  input wire logic coarse_locked_in,
  input wire logic ref_loss_in,
  input wire logic crystal_pin_osc_ready_in,
  input wire logic [1:0] sys_clk_source_in,
  // oscillator controls
  output logic relax_osc_power_down,
  output logic relax_osc_standby_n,
  output logic crystal_pin_low_power,
  output logic direct_clock_mode,
  output logic crystal_pin_range_high,
  output logic ext_input_select,
  output logic [9:0] relax_trim,
  // pll controls
  output logic pll_off_ctrl,
  output logic prescaler_ext_select,
  // interrupt
  output logic pll_irq
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic access;
  logic wr;
  logic hit_status;
  logic hit_osc;
  logic hit_main;
  logic lo_lanes;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign hit_status = paddr == ADDR_STATUS;
  assign hit_osc = paddr == ADDR_OSC_CTRL;
  assign hit_main = paddr == ADDR_MAIN_CTRL;
  assign lo_lanes = pstrb[1:0] == 2'b11;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [15:0] main_ctrl;
  logic [15:0] osc_ctrl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ctrl <= MAIN_CTRL_RESET;
    end else if (wr && hit_main && lo_lanes) begin
      main_ctrl <= pwdata[15:0] & MAIN_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_ctrl <= OSC_CTRL_RESET;
    end else if (wr && hit_osc && lo_lanes) begin
      osc_ctrl <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relax_osc_power_down <= OSC_CTRL_RESET[OC_RELAX_PD];
      relax_osc_standby_n <= OSC_CTRL_RESET[OC_RELAX_SB_N];
      crystal_pin_low_power <= OSC_CTRL_RESET[OC_CRYSTAL_PIN_LOW_PWR];
      direct_clock_mode <= OSC_CTRL_RESET[OC_DIRECT_CLK];
      crystal_pin_range_high <= OSC_CTRL_RESET[OC_RANGE];
      ext_input_select <= OSC_CTRL_RESET[OC_EXT_INPUT_SELECT];
      relax_trim <= OSC_CTRL_RESET[9:0];
      pll_off_ctrl <= MAIN_CTRL_RESET[MC_PLL_OFF];
      prescaler_ext_select <= MAIN_CTRL_RESET[MC_PRESCALER_EXT];
    end else begin
      relax_osc_power_down <= osc_ctrl[OC_RELAX_PD];
      relax_osc_standby_n <= osc_ctrl[OC_RELAX_SB_N];
      crystal_pin_low_power <= osc_ctrl[OC_CRYSTAL_PIN_LOW_PWR];
      direct_clock_mode <= osc_ctrl[OC_DIRECT_CLK];
      crystal_pin_range_high <= osc_ctrl[OC_RANGE];
      ext_input_select <= osc_ctrl[OC_EXT_INPUT_SELECT];
      relax_trim <= osc_ctrl[9:0];
      pll_off_ctrl <= main_ctrl[MC_PLL_OFF];
      prescaler_ext_select <= main_ctrl[MC_PRESCALER_EXT];
    end
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  logic clr_status;
  logic fine_unlock_flag;
  logic coarse_unlock_flag;
  logic ref_loss_flag;
  assign clr_status = wr && hit_status && lo_lanes;

  cssc_flag u_fine_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(!fine_locked_in && main_ctrl[MC_FINE_IE]),
    .clr(clr_status && pwdata[ST_FINE_UNLOCK]),
    .flag(fine_unlock_flag)
  );

  cssc_flag u_coarse_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(!coarse_locked_in && main_ctrl[MC_COARSE_IE]),
    .clr(clr_status && pwdata[ST_COARSE_UNLOCK]),
    .flag(coarse_unlock_flag)
  );

  cssc_flag u_ref_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(ref_loss_in),
    .clr(clr_status && pwdata[ST_REF_LOSS]),
    .flag(ref_loss_flag)
  );

  // ------------------------------------------------------------
  // pll power-down status
  // ------------------------------------------------------------
  logic pll_off_status;
  cssc_delay #(
    .DEPTH(PLL_OFF_DELAY)
  ) u_pll_off_delay (
    .pclk(pclk),
    .presetn(presetn),
    .din(main_ctrl[MC_PLL_OFF]),
    .dout(pll_off_status)
  );

  // ------------------------------------------------------------
  // status word and interrupt
  // ------------------------------------------------------------
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_FINE_UNLOCK] = fine_unlock_flag;
    status_word[ST_COARSE_UNLOCK] = coarse_unlock_flag;
    status_word[ST_REF_LOSS] = ref_loss_flag;
    status_word[ST_FINE_LOCKED] = fine_locked_in;
    status_word[ST_COARSE_LOCKED] = coarse_locked_in;
    status_word[ST_PLL_OFF] = pll_off_status;
    status_word[ST_CRYSTAL_PIN_READY] = crystal_pin_osc_ready_in;
    status_word[1:0] = sys_clk_source_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_irq <= 1'b0;
    end else begin
      pll_irq <= (fine_unlock_flag && main_ctrl[MC_FINE_IE])
        || (coarse_unlock_flag && main_ctrl[MC_COARSE_IE])
        || (ref_loss_flag && main_ctrl[MC_REF_LOSS_IE]);
    end
  end

  // ------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------
  logic unmapped;
  logic [31:0] next_prdata;
  assign unmapped = !(hit_status || hit_osc || hit_main);
  always_comb begin
    next_prdata = 32'h00000000;
    if (hit_status) begin
      next_prdata[15:0] = status_word;
    end else if (hit_osc) begin
      next_prdata[15:0] = osc_ctrl;
    end else if (hit_main) begin
      next_prdata[15:0] = main_ctrl;
    end
  end

  // no wait states: setup cycle loads read data, access completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_irq_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (ref_loss_flag && main_ctrl[MC_REF_LOSS_IE]) |=> pll_irq)
    else $error("irq not raised for enabled reference loss");
  a_fine_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!fine_unlock_flag && !main_ctrl[MC_FINE_IE]) |=> !fine_unlock_flag)
    else $error("fine unlock flag set while disabled");
  a_coarse_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (!coarse_locked_in && main_ctrl[MC_COARSE_IE]) |=> coarse_unlock_flag)
    else $error("coarse unlock flag not set");
  a_ref_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && pwdata[ST_REF_LOSS] && !ref_loss_in) |=> !ref_loss_flag)
    else $error("reference loss flag not cleared");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (status_word[12:7] == 6'h00) && !status_word[3])
    else $error("reserved status bit nonzero");
  a_pll_off_delay: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(main_ctrl[MC_PLL_OFF]) |-> !pll_off_status [*4] ##1 pll_off_status)
    else $error("pll power-down status not four clocks late");
  a_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && !pwdata[ST_FINE_UNLOCK] && fine_unlock_flag) |=> fine_unlock_flag)
    else $error("flag lost on zero write");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (ref_loss_in && clr_status && pwdata[ST_REF_LOSS]) |=> ref_loss_flag)
    else $error("clear won over set");
  a_trim_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 relax_trim == $past(pwdata[9:0], 2))
    else $error("trim output mismatch");

  // ------------------------------------------------------------
  // checks: flag set and clear
  // ------------------------------------------------------------
  a_fine_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (!fine_locked_in && main_ctrl[MC_FINE_IE]) |=> fine_unlock_flag)
    else $error("fine unlock flag not set");
  a_fine_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && pwdata[ST_FINE_UNLOCK] && (fine_locked_in || !main_ctrl[MC_FINE_IE]))
    |=> !fine_unlock_flag)
    else $error("fine unlock flag not cleared");
  a_coarse_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!coarse_unlock_flag && !main_ctrl[MC_COARSE_IE]) |=> !coarse_unlock_flag)
    else $error("coarse unlock flag set while disabled");
  a_coarse_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && pwdata[ST_COARSE_UNLOCK] && (coarse_locked_in || !main_ctrl[MC_COARSE_IE]))
    |=> !coarse_unlock_flag)
    else $error("coarse unlock flag not cleared");
  a_ref_sets: assert property (@(posedge pclk) disable iff (!presetn)
    ref_loss_in |=> ref_loss_flag)
    else $error("reference loss flag not set");
  a_ref_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (ref_loss_flag && !(clr_status && pwdata[ST_REF_LOSS])) |=> ref_loss_flag)
    else $error("reference loss flag dropped without clear");
  a_coarse_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && !pwdata[ST_COARSE_UNLOCK] && coarse_unlock_flag) |=> coarse_unlock_flag)
    else $error("coarse flag lost on zero write");
  a_ref_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_status && !pwdata[ST_REF_LOSS] && ref_loss_flag) |=> ref_loss_flag)
    else $error("reference flag lost on zero write");
  a_fine_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (!fine_locked_in && main_ctrl[MC_FINE_IE] && clr_status && pwdata[ST_FINE_UNLOCK])
    |=> fine_unlock_flag)
    else $error("fine clear won over set");

  // ------------------------------------------------------------
  // checks: interrupt and status word
  // ------------------------------------------------------------
  a_irq_fine: assert property (@(posedge pclk) disable iff (!presetn)
    (fine_unlock_flag && main_ctrl[MC_FINE_IE]) |=> pll_irq)
    else $error("irq not raised for enabled fine unlock");
  a_irq_coarse: assert property (@(posedge pclk) disable iff (!presetn)
    (coarse_unlock_flag && main_ctrl[MC_COARSE_IE]) |=> pll_irq)
    else $error("irq not raised for enabled coarse unlock");
  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !((fine_unlock_flag && main_ctrl[MC_FINE_IE])
      || (coarse_unlock_flag && main_ctrl[MC_COARSE_IE])
      || (ref_loss_flag && main_ctrl[MC_REF_LOSS_IE])) |=> !pll_irq)
    else $error("irq raised with no enabled flag");
  a_lock_bits: assert property (@(posedge pclk) disable iff (!presetn)
    (status_word[ST_FINE_LOCKED] == fine_locked_in)
    && (status_word[ST_COARSE_LOCKED] == coarse_locked_in))
    else $error("lock bits do not follow detectors");
  a_pll_off_track: assert property (@(posedge pclk) disable iff (!presetn)
    pll_off_status == $past(main_ctrl[MC_PLL_OFF], 4))
    else $error("pll power-down status not four clocks behind control");
  a_crystal_pin_ready: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[ST_CRYSTAL_PIN_READY] == crystal_pin_osc_ready_in)
    else $error("crystal ready bit wrong");
  a_source_bits: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[1:0] == sys_clk_source_in)
    else $error("clock source status wrong");
  a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_status)
    |=> (prdata[31:16] == 16'h0000) && (prdata[12:7] == 6'h00) && !prdata[3])
    else $error("reserved status bits read nonzero");

  // ------------------------------------------------------------
  // checks: oscillator outputs
  // ------------------------------------------------------------
  a_relax_pd_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 relax_osc_power_down == $past(pwdata[OC_RELAX_PD], 2))
    else $error("relaxation power-down output mismatch");
  a_standby_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 relax_osc_standby_n == $past(pwdata[OC_RELAX_SB_N], 2))
    else $error("standby output mismatch");
  a_low_pwr_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 crystal_pin_low_power == $past(pwdata[OC_CRYSTAL_PIN_LOW_PWR], 2))
    else $error("crystal power level output mismatch");
  a_direct_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 direct_clock_mode == $past(pwdata[OC_DIRECT_CLK], 2))
    else $error("direct clock output mismatch");
  a_range_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 crystal_pin_range_high == $past(pwdata[OC_RANGE], 2))
    else $error("crystal range output mismatch");
  a_ext_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && lo_lanes) |=> ##1 ext_input_select == $past(pwdata[OC_EXT_INPUT_SELECT], 2))
    else $error("external input select output mismatch");
  a_strobe_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_osc && !lo_lanes) |=> $stable(osc_ctrl))
    else $error("oscillator control written without byte strobes");

  // ------------------------------------------------------------
  // checks: bus answer
  // ------------------------------------------------------------
  a_ready_next: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("ready missing in access cycle");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && unmapped) |=> pslverr)
    else $error("no error for unmapped address");
  a_status_write_only: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_status) |=> $stable(osc_ctrl) && $stable(main_ctrl))
    else $error("status write changed a control register");
endmodule : cssc_top
`default_nettype wire

// >>> cssc_tb.sv
// testbench: drives cssc_top over apb and compares it with a bench model
// assumes: lock and oscillator inputs are synchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cssc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic fine_lk = 1'b1;
  logic coarse_lk = 1'b1;
  logic ref_loss = 1'b0;
  logic crystal_pin_rdy = 1'b0;
  logic [1:0] src = 2'b01;
  logic ro_pd, ro_sbn, x_lp, d_clk, x_rng, x_ext, pll_off, pre_ext, pll_irq;
  logic [9:0] trim;
  logic m_fine, m_coarse, m_ref;
  logic [15:0] m_main, d;
  logic [31:0] r;
  logic e;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 32'h52b0224f;

  cssc_top cssc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fine_locked_in(fine_lk),
    .coarse_locked_in(coarse_lk), .ref_loss_in(ref_loss), .crystal_pin_osc_ready_in(crystal_pin_rdy),
    .sys_clk_source_in(src), .relax_osc_power_down(ro_pd), .relax_osc_standby_n(ro_sbn),
    .crystal_pin_low_power(x_lp), .direct_clock_mode(d_clk), .crystal_pin_range_high(x_rng),
    .ext_input_select(x_ext), .relax_trim(trim), .pll_off_ctrl(pll_off),
    .prescaler_ext_select(pre_ext), .pll_irq(pll_irq));

  always #20 pclk = ~pclk;

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [9:0] a, input logic [15:0] wd,
      input logic [3:0] st);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge between transfers
    @(posedge pclk);
  endtask : apb

  task automatic set_main(input logic [15:0] v);
    apb(1'b1, ADDR_MAIN_CTRL, v, 4'hf);
    m_main = v;
    repeat (5) @(posedge pclk);
  endtask : set_main

  // model of the status word and the interrupt level
  function automatic logic [31:0] exp_stat();
    return {16'h0000, m_fine, m_coarse, m_ref, 6'h00, fine_lk, coarse_lk, m_main[0], 1'b0,
      crystal_pin_rdy, src};
  endfunction : exp_stat

  task automatic chk_stat_irq();
    apb(1'b0, ADDR_STATUS, 16'h0000, 4'hf);
    check("status", r, exp_stat());
    check("irq", 32'(pll_irq), 32'((m_fine & m_main[2]) | (m_coarse & m_main[1])
      | (m_ref & m_main[3])));
  endtask : chk_stat_irq

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {m_fine, m_coarse, m_ref, m_main} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset outputs", 32'({ro_pd, ro_sbn, x_lp, d_clk, x_rng, x_ext, trim}), 32'h4200);
    apb(1'b0, ADDR_OSC_CTRL, 16'h0000, 4'hf);
    check("osc reset", r, 32'h4200);
    // lock drops with enables clear must not set flags
    for (int i = 0; i < 6; i++) begin
      {fine_lk, coarse_lk, crystal_pin_rdy, src} <= 5'($random(seed));
      repeat (2) @(posedge pclk);
      chk_stat_irq();
    end
    {fine_lk, coarse_lk} <= 2'b11;
    set_main(16'h0001);
    chk_stat_irq();
    for (int i = 0; i < 6; i++) begin
      d = 16'($random(seed)) & 16'h7fff;
      apb(1'b1, ADDR_OSC_CTRL, d, 4'hf);
      apb(1'b1, ADDR_OSC_CTRL, ~d, 4'h0);
      apb(1'b0, ADDR_OSC_CTRL, 16'h0000, 4'hf);
      check("osc readback", r, {16'h0000, d});
      check("osc error", 32'(e), 32'h0);
      check("osc outputs", 32'({ro_pd, ro_sbn, x_lp, d_clk, x_rng, x_ext, trim}), 32'(d));
    end
    // relaxation oscillator powers down after the pll is off and the prescaler takes the external input
    apb(1'b1, ADDR_OSC_CTRL, 16'h4200, 4'hf);
    set_main(16'h0011);
    apb(1'b1, ADDR_OSC_CTRL, 16'hc200, 4'hf);
    @(posedge pclk);
    check("relax off", 32'({ro_pd, pll_off, pre_ext}), 32'h7);
    apb(1'b0, 10'h00c, 16'h0000, 4'hf);
    check("unmapped data", r, 32'h0);
    check("unmapped error", 32'(e), 32'h1);
    set_main(16'h0006);
    fine_lk <= 1'b0;
    m_fine = 1'b1;
    repeat (3) @(posedge pclk);
    chk_stat_irq();
    apb(1'b1, ADDR_STATUS, 16'h8000, 4'hf);
    chk_stat_irq();
    fine_lk <= 1'b1;
    apb(1'b1, ADDR_STATUS, 16'h0000, 4'hf);
    chk_stat_irq();
    apb(1'b1, ADDR_STATUS, 16'hffff, 4'hf);
    m_fine = 1'b0;
    @(posedge pclk);
    chk_stat_irq();
    coarse_lk <= 1'b0;
    m_coarse = 1'b1;
    repeat (3) @(posedge pclk);
    chk_stat_irq();
    coarse_lk <= 1'b1;
    set_main(16'h0000);
    chk_stat_irq();
    apb(1'b1, ADDR_STATUS, 16'h4000, 4'hf);
    m_coarse = 1'b0;
    ref_loss <= 1'b1;
    @(posedge pclk);
    ref_loss <= 1'b0;
    m_ref = 1'b1;
    repeat (2) @(posedge pclk);
    chk_stat_irq();
    set_main(16'h0018);
    chk_stat_irq();
    apb(1'b1, ADDR_STATUS, 16'h2000, 4'hf);
    m_ref = 1'b0;
    @(posedge pclk);
    chk_stat_irq();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
